// ### src/sxr_pkg.sv
// shared constants and types for the transceiver reset and lock control
package sxr_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_PLL_RST_NS = 1000;
  localparam int PLL_RST_CYC = (T_PLL_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_LTD_SETTLE_NS = 4000;
  localparam int LTD_SETTLE_CYC = (T_LTD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_LOCK_CYC = 64;
  localparam int OC_BUSY_CYC = 32;
  localparam int RCFG_BUSY_CYC = 8;
  localparam int DW = 20;
  localparam int FIFO_DEPTH = 4;
  localparam logic [3:0] SLIP_MAX = 4'h9;
  // register byte offsets of the controller
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_INT_STAT = 12'h008;
  localparam logic [11:0] REG_INT_MASK = 12'h00c;
  localparam int CTRL_START = 0;
  localparam int CTRL_FORCE_REF = 1;
  localparam int CTRL_FORCE_DATA = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam int EV_TX_READY = 0;
  localparam int EV_RX_READY = 1;
  localparam int EV_FIFO_ERR = 2;
  localparam int EV_LOCK_LOSS = 3;
  typedef enum logic [2:0] {
    SXR_MODE_BASIC = 3'b000,
    SXR_MODE_BASIC_8B10B = 3'b001,
    SXR_MODE_PIPE = 3'b010,
    SXR_MODE_GIGE = 3'b011,
    SXR_MODE_DETLAT = 3'b100
  } sxr_mode_e;
  typedef enum logic [2:0] {
    SXR_PPM_62P5 = 3'b000,
    SXR_PPM_100 = 3'b001,
    SXR_PPM_125 = 3'b010,
    SXR_PPM_200 = 3'b011,
    SXR_PPM_250 = 3'b100,
    SXR_PPM_300 = 3'b101
  } sxr_ppm_e;
  typedef enum logic [2:0] {
    SXR_SEQ_PLL_RST = 3'b000,
    SXR_SEQ_WAIT_PLL = 3'b001,
    SXR_SEQ_WAIT_FREQ = 3'b010,
    SXR_SEQ_SETTLE = 3'b011,
    SXR_SEQ_RUN = 3'b100
  } sxr_seq_e;
  // ppm threshold in tenths of a ppm
  function automatic logic [11:0] sxr_ppm_thr(input logic [2:0] sel);
    case (sel)
      3'h0: sxr_ppm_thr = 12'h271;
      3'h1: sxr_ppm_thr = 12'h3e8;
      3'h2: sxr_ppm_thr = 12'h4e2;
      3'h3: sxr_ppm_thr = 12'h7d0;
      3'h4: sxr_ppm_thr = 12'h9c4;
      default: sxr_ppm_thr = 12'hbb8;
    endcase
  endfunction
  // line rate in units of 0.1 Mbps; proto 0 selects the first radio protocol, 1 the second
  function automatic logic sxr_rate_ok(input logic proto, input logic [15:0] r);
    if (!proto) begin
      sxr_rate_ok = (r == 16'h1800) || (r == 16'h3000) || (r == 16'h6000) || (r == 16'h7800);
    end else begin
      sxr_rate_ok = (r == 16'h1e00) || (r == 16'h3c00) || (r == 16'h7800);
    end
  endfunction
endpackage

// ### src/sxr_if.sv
// link between the transceiver channel and its reset and lock controller
`timescale 1ns/100ps
`default_nettype none
interface sxr_if;
  logic pll_areset;
  logic tx_digital_reset;
  logic rx_analog_reset;
  logic rx_digital_reset;
  logic force_data_lock;
  logic force_ref_lock;
  logic pll_locked;
  logic freq_locked;
  logic signal_detect;
  logic fifo_error;
  logic [3:0] slip_count_output;
  logic busy;
  modport dev (
    input pll_areset, tx_digital_reset, rx_analog_reset, rx_digital_reset,
    input force_data_lock, force_ref_lock,
    output pll_locked, freq_locked, signal_detect, fifo_error, slip_count_output, busy
  );
  modport ctl (
    output pll_areset, tx_digital_reset, rx_analog_reset, rx_digital_reset,
    output force_data_lock, force_ref_lock,
    input pll_locked, freq_locked, signal_detect, fifo_error, slip_count_output, busy
  );
endinterface
`default_nettype wire

// ### src/sxr_channel.sv
// transceiver channel end: pll, clock recovery lock, fifos, status outputs
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - deterministic latency forces registered receive fifo
// - registered fifo is exactly one register stage
// - fifo error high when fifo full or empty, except in deterministic latency or under receive digital reset
// - manual aligner reports slipped bits 0 to 9
// - frequency lock high in lock-to-data only
// - force pair selects auto, reference or data
// - signal detect above threshold, certain modes only
// - low-speed recovered clock only in ethernet mode
// - controller holds pll reset at least 1 us
// - pll reset holds others; release starts locking
// - controller releases transmit reset after pll lock
// - busy pulses at power-up, then on reconfiguration
// - ppm threshold selectable among six values
// - optional separate read strobe for receive fifo
// - deterministic mode checks radio protocol line rates
// - clock recovery starts in lock-to-reference
// - phase detector off in reference, on in data
// - auto mode locks on ppm, pipe needs detect
module sxr_channel import sxr_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link to the controller
  sxr_if.dev lnk,
  // configuration
  input wire logic [2:0] mode,
  input wire logic [2:0] ppm_sel,
  input wire logic tx_fifo_reg,
  input wire logic wa_manual,
  input wire logic core_read_sel,
  input wire logic rate_proto,
  input wire logic [15:0] line_rate,
  input wire logic [7:0] sig_thresh,
  // analog observations, slip and reconfiguration requests
  input wire logic [11:0] meas_ppm,
  input wire logic [7:0] sig_level,
  input wire logic slip_req,
  input wire logic reconfig_req,
  // receive data
  input wire logic [DW-1:0] rx_word_in,
  input wire logic rx_word_in_vld,
  input wire logic core_rd_en,
  output logic [DW-1:0] rx_word_out,
  output logic rx_word_out_vld,
  // transmit data
  input wire logic [DW-1:0] tx_word_in,
  output logic [DW-1:0] tx_word_out,
  // status
  output logic phase_det_en,
  output logic recov_clk_out,
  output logic rate_ok
);
  typedef enum logic {SXR_CDR_LTR = 1'b0, SXR_CDR_LTD = 1'b1} sxr_cdr_e;

  // the pll reset overrides every other reset inside the channel
  logic rxa_rst, rxd_rst, txd_rst, detlat;
  assign rxa_rst = lnk.rx_analog_reset | lnk.pll_areset;
  assign rxd_rst = lnk.rx_digital_reset | lnk.pll_areset;
  assign txd_rst = lnk.tx_digital_reset | lnk.pll_areset;
  assign detlat = (mode == SXR_MODE_DETLAT);

  // pll lock model: locking starts when the pll reset drops
  logic [6:0] lock_cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_q <= 7'h00;
      lnk.pll_locked <= 1'b0;
    end else if (lnk.pll_areset) begin
      lock_cnt_q <= 7'h00;
      lnk.pll_locked <= 1'b0;
    end else if (lock_cnt_q < 7'(PLL_LOCK_CYC)) begin
      lock_cnt_q <= lock_cnt_q + 7'h01;
    end else begin
      lnk.pll_locked <= 1'b1;
    end
  end

  // clock recovery lock state
  sxr_cdr_e cdr_q, cdr_d;
  logic ppm_in, det_req;
  assign ppm_in = meas_ppm < sxr_ppm_thr(ppm_sel);
  assign det_req = (mode == SXR_MODE_PIPE) ? lnk.signal_detect : 1'b1;
  always_comb begin
    unique casez ({lnk.force_data_lock, lnk.force_ref_lock})
      2'b1?: cdr_d = SXR_CDR_LTD;
      2'b01: cdr_d = SXR_CDR_LTR;
      default: cdr_d = (ppm_in && det_req && lnk.pll_locked) ? SXR_CDR_LTD : SXR_CDR_LTR;
    endcase
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cdr_q <= SXR_CDR_LTR;
    end else if (rxa_rst) begin
      cdr_q <= SXR_CDR_LTR;
    end else begin
      cdr_q <= cdr_d;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lnk.freq_locked <= 1'b0;
      phase_det_en <= 1'b0;
    end else begin
      lnk.freq_locked <= (cdr_q == SXR_CDR_LTD);
      phase_det_en <= (cdr_q == SXR_CDR_LTD);
    end
  end

  // signal detect exists only in 8b10b basic and pipe modes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lnk.signal_detect <= 1'b0;
    end else begin
      lnk.signal_detect <= (mode == SXR_MODE_BASIC_8B10B || mode == SXR_MODE_PIPE)
                           && !rxa_rst && (sig_level > sig_thresh);
    end
  end

  // recovered clock at half rate, offered in ethernet mode only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      recov_clk_out <= 1'b0;
    end else begin
      recov_clk_out <= (mode == SXR_MODE_GIGE) && !rxa_rst && !recov_clk_out;
    end
  end

  // word aligner slip counter, wraps after the last bit position
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lnk.slip_count_output <= 4'h0;
    end else if (rxd_rst || !wa_manual) begin
      lnk.slip_count_output <= 4'h0;
    end else if (slip_req) begin
      lnk.slip_count_output <= (lnk.slip_count_output == SLIP_MAX) ? 4'h0
                               : lnk.slip_count_output + 4'h1;
    end
  end

  // busy: offset cancellation once after power-up, later only on reconfiguration
  logic oc_done_q;
  logic [5:0] busy_cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oc_done_q <= 1'b0;
      busy_cnt_q <= 6'h00;
    end else if (busy_cnt_q != 6'h00) begin
      busy_cnt_q <= busy_cnt_q - 6'h01;
    end else if (!oc_done_q && !lnk.pll_areset) begin
      oc_done_q <= 1'b1;
      busy_cnt_q <= 6'(OC_BUSY_CYC);
    end else if (oc_done_q && reconfig_req) begin
      busy_cnt_q <= 6'(RCFG_BUSY_CYC);
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lnk.busy <= 1'b0;
    end else begin
      lnk.busy <= (busy_cnt_q > 6'h01) || (busy_cnt_q == 6'h00 && !oc_done_q && !lnk.pll_areset)
                  || (busy_cnt_q == 6'h00 && oc_done_q && reconfig_req);
    end
  end

  // receive phase compensation fifo
  logic [DW-1:0] mem_q [FIFO_DEPTH];
  logic [2:0] wr_ptr_q, rd_ptr_q;
  logic full, empty, pop, push;
  assign full = (wr_ptr_q[1:0] == rd_ptr_q[1:0]) && (wr_ptr_q[2] != rd_ptr_q[2]);
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign pop = (core_read_sel ? core_rd_en : 1'b1) && !empty;
  assign push = rx_word_in_vld && !full;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= 3'h0;
      rd_ptr_q <= 3'h0;
    end else if (rxd_rst || detlat) begin
      wr_ptr_q <= 3'h0;
      rd_ptr_q <= 3'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 3'h1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 3'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q[1:0]] <= rx_word_in;
    end
  end
  // registered mode bypasses the pointers so latency is one cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_word_out <= '0;
      rx_word_out_vld <= 1'b0;
    end else if (rxd_rst) begin
      rx_word_out_vld <= 1'b0;
    end else if (detlat) begin
      rx_word_out <= rx_word_in;
      rx_word_out_vld <= rx_word_in_vld;
    end else begin
      rx_word_out <= mem_q[rd_ptr_q[1:0]];
      rx_word_out_vld <= pop;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lnk.fifo_error <= 1'b0;
    end else begin
      lnk.fifo_error <= !detlat && !rxd_rst && (full || empty);
    end
  end

  // transmit fifo: registered mode optional in deterministic latency
  logic [DW-1:0] tx_stage_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_stage_q <= '0;
      tx_word_out <= '0;
    end else if (txd_rst) begin
      tx_stage_q <= '0;
      tx_word_out <= '0;
    end else begin
      tx_stage_q <= tx_word_in;
      tx_word_out <= (detlat && tx_fifo_reg) ? tx_word_in : tx_stage_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate_ok <= 1'b0;
    end else begin
      rate_ok <= detlat && sxr_rate_ok(rate_proto, line_rate);
    end
  end
endmodule
`default_nettype wire

// ### src/sxr_ctrl.sv
// reset and lock controller with an axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none
module sxr_ctrl import sxr_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link to the channel
  sxr_if.ctl lnk,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq
);
  sxr_seq_e seq_q;
  logic [9:0] cnt_q;
  logic aw_got_q, w_got_q, start, rd_stat;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] ctrl_q;
  logic [3:0] int_q, mask_q, ev;
  logic fifo_err_q, freq_q;

  // write channel: address and data taken in either order
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_got_q;
  assign s_axi_wready = !w_got_q;
  assign s_axi_bresp = 2'b00;
  logic wr_fire;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
    end else if (wr_fire && w_strb_q[0]) begin
      if (aw_addr_q == REG_CTRL) begin
        ctrl_q <= {29'h0000_0000, w_data_q[2:0]};
      end else if (aw_addr_q == REG_INT_MASK) begin
        mask_q <= w_data_q[3:0];
      end
    end else begin
      ctrl_q[CTRL_START] <= 1'b0;
    end
  end
  assign start = ctrl_q[CTRL_START];

  // read channel
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      unique case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= ctrl_q;
        REG_STATUS: s_axi_rdata <= {20'h0_0000, lnk.slip_count_output, lnk.busy,
                                    lnk.fifo_error, lnk.signal_detect, lnk.freq_locked,
                                    lnk.pll_locked, seq_q};
        REG_INT_STAT: s_axi_rdata <= {28'h000_0000, int_q};
        REG_INT_MASK: s_axi_rdata <= {28'h000_0000, mask_q};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  assign s_axi_rresp = 2'b00;
  assign rd_stat = s_axi_arvalid && s_axi_arready && (s_axi_araddr == REG_INT_STAT);

  // reset sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_q <= SXR_SEQ_PLL_RST;
      cnt_q <= 10'h000;
    end else if (start) begin
      seq_q <= SXR_SEQ_PLL_RST;
      cnt_q <= 10'h000;
    end else begin
      unique case (seq_q)
        SXR_SEQ_PLL_RST: begin
          cnt_q <= cnt_q + 10'h001;
          if (cnt_q == 10'(PLL_RST_CYC)) begin
            seq_q <= SXR_SEQ_WAIT_PLL;
          end
        end
        SXR_SEQ_WAIT_PLL: begin
          cnt_q <= 10'h000;
          if (lnk.pll_locked) begin
            seq_q <= SXR_SEQ_WAIT_FREQ;
          end
        end
        SXR_SEQ_WAIT_FREQ: begin
          if (lnk.freq_locked) begin
            seq_q <= SXR_SEQ_SETTLE;
          end
        end
        SXR_SEQ_SETTLE: begin
          cnt_q <= cnt_q + 10'h001;
          if (!lnk.freq_locked) begin
            seq_q <= SXR_SEQ_WAIT_FREQ;
            cnt_q <= 10'h000;
          end else if (cnt_q == 10'(LTD_SETTLE_CYC - 1)) begin
            seq_q <= SXR_SEQ_RUN;
          end
        end
        SXR_SEQ_RUN: begin
          cnt_q <= 10'h000;
        end
        default: seq_q <= SXR_SEQ_PLL_RST;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lnk.pll_areset <= 1'b1;
      lnk.tx_digital_reset <= 1'b1;
      lnk.rx_analog_reset <= 1'b1;
      lnk.rx_digital_reset <= 1'b1;
    end else begin
      lnk.pll_areset <= (seq_q == SXR_SEQ_PLL_RST) && !(cnt_q == 10'(PLL_RST_CYC));
      lnk.tx_digital_reset <= seq_q inside {SXR_SEQ_PLL_RST, SXR_SEQ_WAIT_PLL};
      lnk.rx_analog_reset <= seq_q inside {SXR_SEQ_PLL_RST, SXR_SEQ_WAIT_PLL};
      lnk.rx_digital_reset <= (seq_q != SXR_SEQ_RUN);
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lnk.force_ref_lock <= 1'b0;
      lnk.force_data_lock <= 1'b0;
    end else begin
      lnk.force_ref_lock <= ctrl_q[CTRL_FORCE_REF];
      lnk.force_data_lock <= ctrl_q[CTRL_FORCE_DATA];
    end
  end

  // sticky events; a new event in the clearing read cycle survives
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fifo_err_q <= 1'b0;
      freq_q <= 1'b0;
    end else begin
      fifo_err_q <= lnk.fifo_error;
      freq_q <= lnk.freq_locked;
    end
  end
  always_comb begin
    ev = 4'h0;
    ev[EV_TX_READY] = (seq_q == SXR_SEQ_WAIT_PLL) && lnk.pll_locked && !start;
    ev[EV_RX_READY] = (seq_q == SXR_SEQ_SETTLE) && lnk.freq_locked && !start
                      && (cnt_q == 10'(LTD_SETTLE_CYC - 1));
    ev[EV_FIFO_ERR] = lnk.fifo_error && !fifo_err_q && (seq_q == SXR_SEQ_RUN);
    ev[EV_LOCK_LOSS] = freq_q && !lnk.freq_locked && (seq_q == SXR_SEQ_RUN);
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      int_q <= (rd_stat ? 4'h0 : int_q) | ev;
      irq <= |(((rd_stat ? 4'h0 : int_q) | ev) & mask_q);
    end
  end
endmodule
`default_nettype wire

// ### bench/sxr_sva.sv
// link assertions between channel and controller
`timescale 1ns/100ps
`default_nettype none
module sxr_sva import sxr_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // controller to channel
  input wire logic pll_areset,
  input wire logic tx_digital_reset,
  input wire logic rx_analog_reset,
  input wire logic rx_digital_reset,
  input wire logic force_data_lock,
  input wire logic force_ref_lock,
  // channel to controller
  input wire logic pll_locked,
  input wire logic freq_locked,
  input wire logic signal_detect,
  input wire logic fifo_error,
  input wire logic [3:0] slip_count_output,
  input wire logic busy
);
  logic [15:0] rst_cnt_q;
  logic [15:0] lock_cnt_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // long holds are counted here; repetition operators would not unroll that far
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_q <= 16'h0000;
    end else if (pll_areset) begin
      rst_cnt_q <= rst_cnt_q + 16'h0001;
    end else begin
      rst_cnt_q <= 16'h0000;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_q <= 16'h0000;
    end else if (freq_locked) begin
      lock_cnt_q <= lock_cnt_q + 16'h0001;
    end else begin
      lock_cnt_q <= 16'h0000;
    end
  end
  pll_hold_min_a: assert property ($fell(pll_areset) |-> rst_cnt_q >= 16'(PLL_RST_CYC))
    else $error("pll reset released too early");
  resets_held_a: assert property (pll_areset |-> tx_digital_reset && rx_analog_reset
    && rx_digital_reset) else $error("reset dropped under pll reset");
  pll_lock_start_a: assert property ($fell(pll_areset) |-> ##[1:100] pll_locked)
    else $error("pll did not lock");
  no_early_lock_a: assert property (pll_areset [*2] |-> !pll_locked)
    else $error("pll locked under reset");
  tx_after_lock_a: assert property ($fell(tx_digital_reset) |-> $past(pll_locked))
    else $error("transmit reset released before lock");
  rx_after_settle_a: assert property ($fell(rx_digital_reset) |-> !rx_analog_reset
    && lock_cnt_q >= 16'(LTD_SETTLE_CYC - 1)) else $error("receive reset released early");
  slip_range_a: assert property (slip_count_output <= SLIP_MAX)
    else $error("slip count out of range");
  ref_forced_a: assert property ((force_ref_lock && !force_data_lock) [*3] |-> !freq_locked)
    else $error("frequency lock under forced reference");
  data_forced_a: assert property ((force_data_lock && !rx_analog_reset) [*3] |-> freq_locked)
    else $error("no frequency lock under forced data");
  busy_pulse_a: assert property ($rose(busy) |-> busy [*8] ##[1:32] !busy)
    else $error("busy pulse length wrong");
  cover property ($fell(tx_digital_reset));
  cover property ($fell(rx_digital_reset));
  cover property ($rose(busy));
  cover property (force_data_lock && freq_locked);
endmodule
`default_nettype wire

// ### bench/sxr_bench.sv
// testbench: controller and channel joined by the link
`timescale 1ns/100ps
`default_nettype none
module sxr_bench import sxr_pkg::*;;
  logic clock = 1'b0, rst_n = 1'b0, tx_fifo_reg = 1'b1, wa_manual = 1'b0, core_read_sel = 1'b0;
  logic rate_proto = 1'b0, slip_req = 1'b0, reconfig_req = 1'b0, rx_word_in_vld = 1'b1;
  logic core_rd_en = 1'b0, rx_word_out_vld, phase_det_en, recov_clk_out, rate_ok, irq;
  logic [2:0] mode = SXR_MODE_DETLAT, ppm_sel = 3'h0;
  logic [15:0] line_rate = 16'h1800;
  logic [7:0] sig_thresh = 8'h40, sig_level = 8'h80;
  logic [11:0] meas_ppm = 12'h010, s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [DW-1:0] rx_word_in = '0, tx_word_in = '0, rx_word_out, tx_word_out;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errors = 0, tests_run = 0;
  int thr[6] = '{625, 1000, 1250, 2000, 2500, 3000};
  // {accepted, protocol, rate in 0.1 Mbps}
  logic [17:0] rt[9] = '{18'h2_1800, 18'h2_3000, 18'h2_6000, 18'h2_7800, 18'h3_1e00,
    18'h3_3c00, 18'h3_7800, 18'h0_1e00, 18'h1_1800};
  // {mode, detect expected}
  logic [3:0] md[4] = '{4'h0, 4'h3, 4'h5, 4'h6};
  sxr_if lnk ();
  sxr_channel sxr_channel_inst (.*);
  sxr_ctrl sxr_ctrl_inst (.*);
  sxr_sva sxr_sva_inst (.clock(clock), .rst_n(rst_n), .pll_areset(lnk.pll_areset),
    .tx_digital_reset(lnk.tx_digital_reset), .rx_analog_reset(lnk.rx_analog_reset),
    .rx_digital_reset(lnk.rx_digital_reset), .force_data_lock(lnk.force_data_lock),
    .force_ref_lock(lnk.force_ref_lock), .pll_locked(lnk.pll_locked),
    .freq_locked(lnk.freq_locked), .signal_detect(lnk.signal_detect),
    .fifo_error(lnk.fifo_error), .slip_count_output(lnk.slip_count_output), .busy(lnk.busy));
  always #2 clock = ~clock;
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic complete_run;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    complete_run;
  end
  initial begin
    logic [DW-1:0] w;
    logic p, seen;
    int chg, k;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    axi_read(REG_CTRL, rd);
    check("ctrl reset", CTRL_RST, rd);
    axi_read(REG_INT_MASK, rd);
    check("mask reset", {28'h000_0000, MASK_RST}, rd);
    for (k = 0; k < 200 && rd[2:0] !== SXR_SEQ_RUN; k++) begin
      cyc(20);
      axi_read(REG_STATUS, rd);
    end
    check("status", 32'h0000_001c, rd & 32'h0000_00ff);
    check("tx reset", 32'h0, lnk.tx_digital_reset);
    axi_read(REG_INT_STAT, rd);
    check("ready events", 32'h0000_0003, rd);
    axi_read(REG_INT_STAT, rd);
    check("events cleared", 32'h0000_0000, rd);
    // back-to-back words through the registered stages
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      w = rx_word_in;
      rx_word_in <= {w[DW-2:0], ~w[DW-1]};
      tx_word_in <= {w[DW-2:0], ~w[DW-1]};
      #1;
      check("rx word", 32'(w), 32'(rx_word_out));
      check("tx word", 32'(w), 32'(tx_word_out));
      check("fifo err detlat", 32'h0, lnk.fifo_error);
    end
    foreach (rt[i]) begin
      @(posedge clock);
      rate_proto <= rt[i][16];
      line_rate <= rt[i][15:0];
      cyc(3);
      check("rate ok", 32'(rt[i][17]), 32'(rate_ok));
    end
    axi_write(REG_INT_MASK, 32'h0000_0008);
    cyc(2);
    check("irq idle", 32'h0, irq);
    @(posedge clock);
    meas_ppm <= 12'h7ff;
    cyc(8);
    check("irq lock loss", 32'h1, irq);
    axi_read(REG_INT_STAT, rd);
    check("lock loss", 32'h0000_0008, rd & 32'h0000_0008);
    cyc(3);
    check("irq cleared", 32'h0, irq);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      ppm_sel <= 3'(i);
      meas_ppm <= 12'(thr[i] - 1);
      cyc(6);
      check("ppm inside", 32'h1, lnk.freq_locked);
      @(posedge clock);
      meas_ppm <= 12'(thr[i] + 1);
      cyc(6);
      check("ppm outside", 32'h0, lnk.freq_locked);
    end
    for (int i = 0; i < 4; i++) begin
      axi_write(REG_CTRL, 32'(i << 1));
      cyc(6);
      check("forced lock", 32'(i >> 1), lnk.freq_locked);
      check("phase det", 32'(i >> 1), phase_det_en);
    end
    axi_write(REG_CTRL, 32'h0000_0000);
    @(posedge clock);
    meas_ppm <= 12'h010;
    mode <= SXR_MODE_BASIC;
    rx_word_in_vld <= 1'b0;
    cyc(4);
    check("fifo empty", 32'h1, lnk.fifo_error);
    core_read_sel <= 1'b1;
    rx_word_in_vld <= 1'b1;
    cyc(6);
    check("full", 32'h1, lnk.fifo_error);
    core_rd_en <= 1'b1;
    cyc(2);
    check("read", 32'(rx_word_in), 32'(rx_word_out));
    check("read vld", 32'h1, rx_word_out_vld);
    foreach (md[i]) begin
      @(posedge clock);
      mode <= md[i][3:1];
      cyc(3);
      check("detect", 32'(md[i][0]), lnk.signal_detect);
      chg = 0;
      p = recov_clk_out;
      repeat (8) begin
        cyc(1);
        if (recov_clk_out !== p) chg++;
        p = recov_clk_out;
      end
      check("recov clock", 32'(md[i][3:1] == SXR_MODE_GIGE), 32'(chg > 0));
    end
    @(posedge clock);
    mode <= SXR_MODE_BASIC_8B10B;
    sig_level <= 8'h20;
    cyc(3);
    check("detect low", 32'h0, lnk.signal_detect);
    @(posedge clock);
    wa_manual <= 1'b1;
    for (int i = 1; i < 11; i++) begin
      @(posedge clock);
      slip_req <= 1'b1;
      @(posedge clock);
      slip_req <= 1'b0;
      cyc(3);
      check("slip", 32'(i % 10), lnk.slip_count_output);
    end
    @(posedge clock);
    reconfig_req <= 1'b1;
    @(posedge clock);
    reconfig_req <= 1'b0;
    cyc(2);
    check("busy", 32'h1, lnk.busy);
    cyc(12);
    check("busy end", 32'h0, lnk.busy);
    axi_write(12'h040, 32'hffff_ffff);
    axi_read(12'h040, rd);
    check("unmapped", 32'h0000_0000, rd);
    axi_write(REG_CTRL, 32'h0000_0001);
    cyc(2);
    check("pll reset", 32'h1, lnk.pll_areset);
    seen = 1'b0;
    for (k = 0; k < 3000 && lnk.tx_digital_reset !== 1'b0; k++) begin
      cyc(1);
      if (lnk.busy) seen = 1'b1;
    end
    check("no busy again", 32'h0, seen);
    check("tx release", 32'h0, lnk.tx_digital_reset);
    complete_run;
  end
endmodule
`default_nettype wire
